/* dv/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"
module flash_dev_model #(
	parameter ERASE_TICKS = 400,
	parameter SUSP_NS = 5000
) (
	input wire logic [21:0] addr_i,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [15:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic wp_n_i,
	input wire logic lock_i,
	output logic [15:0] dq_o,
	output logic rb_low_o
);
	localparam [47:0] CODES = {`CODE_UNLOCK1, `CODE_UNLOCK2, `CODE_ERASE_SETUP,
		`CODE_UNLOCK1, `CODE_UNLOCK2, `CODE_CHIP_ERASE};
	localparam [71:0] ADRS = {`ADDR_UNLOCK1, `ADDR_UNLOCK2, `ADDR_UNLOCK1,
		`ADDR_UNLOCK1, `ADDR_UNLOCK2, `ADDR_CHIP_ERASE};
	logic [2:0] seq_r = 3'h0;
	logic chip_r = 0, blk_r = 0, susp_r = 0, sreq_r = 0, tog_r = 0, stuck_r = 0, hit, go;
	logic [21:0] blk_a = 22'h000000;
	logic [15:0] last_w = 16'h0000;
	integer left = 0, erase_cnt = 0;
	realtime susp_t = 0;
	wire wr = we_n_i | ce_n_i;
	wire rd = oe_n_i | ce_n_i;
	wire busy = (chip_r | blk_r) & ~susp_r;
	wire in_blk = susp_r & (addr_i[21:15] == blk_a[21:15]);
	wire [15:0] rd_w = busy ? {9'h000, tog_r, 3'h0, tog_r, 2'h0} :
		in_blk ? {8'h00, 2'h3, 3'h0, tog_r, 2'h0} :
		stuck_r ? 16'h007F : 16'hFFFF;
	// Released bus shows the inverse of the last word, never a stale match
	assign dq_o = dq_oe_i ? dq_i : (!rd ? rd_w : ~last_w);
	assign rb_low_o = busy;
	always @(posedge wr)
	begin
		hit = dq_i[7:0] == CODES[8*(5-seq_r)+:8] && addr_i[11:0] == ADRS[12*(5-seq_r)+:12];
		if (!sreq_r)
			susp_t = $realtime + SUSP_NS;
		sreq_r = sreq_r | (blk_r & !susp_r & dq_i[7:0] == `CODE_SUSPEND);
		if (susp_r && dq_i[7:0] == `CODE_RESUME)
			susp_r = 0;
		else if (!blk_r && !chip_r)
		begin
			go = hit && seq_r == 3'h5 && wp_n_i && !lock_i;
			seq_r = hit && seq_r != 3'h5 ? seq_r + 3'h1 : 3'h0;
			chip_r = go;
			left = go ? ERASE_TICKS : left;
			erase_cnt = erase_cnt + go;
		end
	end
	always #100
	begin
		susp_r = susp_r | (sreq_r && $realtime >= susp_t);
		sreq_r = sreq_r & !susp_r;
		left = left - (busy ? 1 : 0);
		chip_r = chip_r & (left > 0);
		blk_r = blk_r & (left > 0);
	end
	always @(posedge rd)
	begin
		last_w = rd_w;
		tog_r = !tog_r;
	end
	task start_block(input logic [21:0] a);
	begin
		blk_a = a;
		blk_r = 1;
		left = ERASE_TICKS;
	end
	endtask
endmodule
`default_nettype wire

/* dv/flash_erase_host_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"
module flash_erase_host_chk (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic [1:0] cmd_i,
	input wire logic bypass_active_i,
	input wire logic done_o,
	input wire logic refused_o,
	input wire logic suspended_o,
	input wire logic busy_o,
	input wire logic flash_ce_n_o,
	input wire logic flash_we_n_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_o,
	input wire logic ready_busy_n_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ----------------
	// Answers, strobes and busy
	// ----------------
	sequence s_tk;
		cmd_valid_i && cmd_ready_o;
	endsequence
	sequence s_wr_end;
		!flash_we_n_o ##1 flash_we_n_o;
	endsequence
	property p_byp; s_tk ##0 (bypass_active_i && cmd_i != `UCMD_STATUS) |=> refused_o; endproperty
	a_byp: assert property (p_byp) else $error("bypass cmd kept");
	property p_res; s_tk ##0 (cmd_i == `UCMD_RESUME && !suspended_o) |=> refused_o; endproperty
	a_res: assert property (p_res) else $error("idle resume kept");
	property p_ers; s_tk ##0 (cmd_i == `UCMD_CHIP_ERASE && suspended_o) |=> refused_o; endproperty
	a_ers: assert property (p_ers) else $error("erase kept");
	property p_one; done_o || refused_o |=> !done_o && !refused_o; endproperty
	a_one: assert property (p_one) else $error("double answer");
	property p_sus; $rose(suspended_o) |-> done_o; endproperty
	a_sus: assert property (p_sus) else $error("suspend silent");
	property p_wsel; !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o; endproperty
	a_wsel: assert property (p_wsel) else $error("strobe unselected");
	property p_wdat; s_wr_end |-> flash_dq_oe_o && $stable(flash_dq_o); endproperty
	a_wdat: assert property (p_wdat) else $error("data moved at strobe");
	property p_busy; !ready_busy_n_i [*5] |-> busy_o; endproperty
	a_busy: assert property (p_busy) else $error("busy missed");
endmodule
bind flash_erase_host flash_erase_host_chk chk_u (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
	.cmd_i(cmd_i), .bypass_active_i(bypass_active_i), .done_o(done_o), .refused_o(refused_o),
	.suspended_o(suspended_o), .busy_o(busy_o), .flash_ce_n_o(flash_ce_n_o),
	.flash_we_n_o(flash_we_n_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
	.ready_busy_n_i(ready_busy_n_i)
);
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"
module tb;
	localparam GAP = 400;
	localparam BLK = 22'h050000;
	localparam A_DONE = 16'h0000;
	localparam A_REF = 16'h0002;
	logic clk = 0, rst_n = 0, cmd_valid = 0, bypass = 0, wp_n = 1, lock = 0, saw_busy = 0;
	logic [1:0] cmd = 2'h0;
	logic [21:0] cmd_addr = 22'h000000;
	logic [15:0] res, s1;
	wire cmd_ready, done, fail, refused, suspended, busy, ce_n, we_n, oe_n, dq_oe, rb_low, rb_n;
	wire [15:0] status, dq_h, dq_b;
	wire [21:0] fa;
	integer n_mismatch = 0, check_count = 0, n;
	always #10 clk = ~clk;
	always @(posedge clk)
		saw_busy <= saw_busy | (busy === 1'b1);
	flash_erase_host #(.AW(22), .RESUME_GAP_CYC(GAP)) dut_u (
		.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.cmd_addr_i(cmd_addr), .bypass_active_i(bypass), .cmd_ready_o(cmd_ready),
		.done_o(done), .fail_o(fail), .refused_o(refused), .suspended_o(suspended),
		.busy_o(busy), .status_o(status), .flash_addr_o(fa), .flash_ce_n_o(ce_n),
		.flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_dq_o(dq_h),
		.flash_dq_oe_o(dq_oe), .flash_dq_i(dq_b), .ready_busy_n_i(rb_n));
	flash_dev_model dev_u (
		.addr_i(fa), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .dq_i(dq_h),
		.dq_oe_i(dq_oe), .wp_n_i(wp_n), .lock_i(lock), .dq_o(dq_b), .rb_low_o(rb_low));
	// Pull-up on the shared line; only the device pulls low
	assign rb_n = rb_low ? 1'b0 : 1'b1;
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		check_count = check_count + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task issue(input logic [1:0] c, input logic [21:0] a, input integer lim);
		integer i;
	begin
		res = 16'h0003;
		@(posedge clk);
		#2;
		cmd_valid = 1'b1;
		cmd = c;
		cmd_addr = a;
		@(negedge clk);
		for (i = 0; i < 200 && cmd_ready !== 1'b1; i = i + 1)
			@(negedge clk);
		@(posedge clk);
		#2;
		cmd_valid = 1'b0;
		for (i = 0; i < lim && res == 16'h0003; i = i + 1)
		begin
			@(negedge clk);
			if (done === 1'b1)
				res = A_DONE;
			else if (fail === 1'b1)
				res = 16'h0001;
			else if (refused === 1'b1)
				res = A_REF;
		end
	end
	endtask
	task t_erase;
	begin
		n = dev_u.erase_cnt;
		issue(`UCMD_CHIP_ERASE, 22'h000555, 8000);
		chk("erase answer", A_DONE, res);
		chk("erase count", n[15:0] + 16'h0001, dev_u.erase_cnt[15:0]);
		chk("busy seen", 16'h0001, {15'h0000, saw_busy});
		chk("poll bit", 16'h0080, status & 16'h0080);
		s1 = dev_u.erase_cnt[15:0];
		for (n = 0; n < 2; n = n + 1)
		begin
			wp_n = n[0];
			lock = n[0];
			issue(`UCMD_CHIP_ERASE, 22'h000555, 2000);
			chk("blocked erase", s1, dev_u.erase_cnt[15:0]);
		end
		// Status that never completes must end in fail at the first re-read
		dev_u.stuck_r = 1;
		issue(`UCMD_CHIP_ERASE, 22'h000555, 2000);
		chk("apparent failure", 16'h0001, res);
		dev_u.stuck_r = 0;
		wp_n = 1;
		lock = 0;
	end
	endtask
	task t_susp;
	begin
		dev_u.start_block(BLK);
		issue(`UCMD_SUSPEND, BLK, 3000);
		chk("suspend answer", A_DONE, res);
		chk("read mode", 16'h0001, {15'h0000, dev_u.susp_r});
		chk("suspended", 16'h0001, {15'h0000, suspended});
		issue(`UCMD_STATUS, BLK, 100);
		s1 = status;
		issue(`UCMD_STATUS, BLK + 22'h000010, 100);
		chk("held bits", 16'h00C0, status & s1 & 16'h00C0);
		chk("suspend toggle", 16'h0004, (status ^ s1) & 16'h0004);
		issue(`UCMD_STATUS, 22'h200000, 100);
		chk("other block", 16'hFFFF, status);
		issue(`UCMD_CHIP_ERASE, 22'h000555, 100);
		chk("erase in suspend", A_REF, res);
		@(posedge clk);
		#2;
		bypass = 1;
		for (n = 0; n < 3; n = n + 1)
		begin
			issue(n[1:0], BLK, 100);
			chk("bypass answer", A_REF, res);
		end
		@(posedge clk);
		#2;
		bypass = 0;
	end
	endtask
	task t_resume;
	begin
		dev_u.left = 2;
		issue(`UCMD_RESUME, 22'h3FFFFF, 2000);
		chk("resume answer", A_DONE, res);
		chk("suspend cleared", 16'h0000, {15'h0000, suspended});
		dev_u.start_block(BLK);
		issue(`UCMD_SUSPEND, BLK, 100);
		chk("early suspend", A_REF, res);
		repeat (GAP) @(posedge clk);
		issue(`UCMD_SUSPEND, BLK, 3000);
		chk("late suspend", A_DONE, res);
		issue(`UCMD_RESUME, BLK, 8000);
		chk("erase done", 16'h0000, {15'h0000, dev_u.blk_r});
		issue(`UCMD_RESUME, BLK, 100);
		chk("idle resume", A_REF, res);
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		#2;
		rst_n = 1;
		t_erase;
		t_susp;
		t_resume;
		end_of_test;
	end
	initial
	begin
		#1500000;
		n_mismatch = n_mismatch + 1;
		end_of_test;
	end
endmodule
`default_nettype wire

/* rtl/flash_bus_cycle.v */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"

module flash_bus_cycle #(
	parameter AW = 22
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire start_i,
	input wire write_i,
	input wire [AW-1:0] addr_i,
	input wire [15:0] wdata_i,
	output reg done_o,
	output reg [15:0] rdata_o,
	output reg [AW-1:0] flash_addr_o,
	output reg flash_ce_n_o,
	output reg flash_we_n_o,
	output reg flash_oe_n_o,
	output reg [15:0] flash_dq_o,
	output reg flash_dq_oe_o,
	input wire [15:0] flash_dq_i
);

	localparam S_IDLE = 2'h0;
	localparam S_LOW = 2'h1;
	localparam S_REC = 2'h2;
	localparam [3:0] WE_LAST = `WE_LOW_CYC - 1;
	localparam [3:0] RD_LAST = `RD_LOW_CYC - 1;
	localparam [3:0] REC_LAST = `RECOVER_CYC - 1;

	reg [1:0] state_r;
	reg [3:0] cnt_r;
	reg wr_r;
	reg [15:0] dq_meta_r;
	reg [15:0] dq_sync_r;

	// ----------------------------------------
	// Data bus synchroniser
	// ----------------------------------------
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dq_meta_r <= 16'h0000;
			dq_sync_r <= 16'h0000;
		end
		else
		begin
			dq_meta_r <= flash_dq_i;
			dq_sync_r <= dq_meta_r;
		end
	end

	// ----------------------------------------
	// Strobe sequencing
	// ----------------------------------------
	// Address is held through recovery so status reads see a stable address
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= S_IDLE;
			cnt_r <= 4'h0;
			wr_r <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0000;
			flash_addr_o <= {AW{1'b0}};
			flash_ce_n_o <= 1'b1;
			flash_we_n_o <= 1'b1;
			flash_oe_n_o <= 1'b1;
			flash_dq_o <= 16'h0000;
			flash_dq_oe_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			case (state_r)
				S_IDLE:
				begin
					if (start_i)
					begin
						wr_r <= write_i;
						flash_addr_o <= addr_i;
						flash_dq_o <= wdata_i;
						flash_dq_oe_o <= write_i;
						flash_ce_n_o <= 1'b0;
						flash_we_n_o <= ~write_i;
						flash_oe_n_o <= write_i;
						cnt_r <= write_i ? WE_LAST : RD_LAST;
						state_r <= S_LOW;
					end
				end
				S_LOW:
				begin
					if (cnt_r != 4'h0)
						cnt_r <= cnt_r - 4'h1;
					else
					begin
						// Rising edge of the strobe latches data / ends the read
						if (!wr_r)
							rdata_o <= dq_sync_r;
						flash_ce_n_o <= 1'b1;
						flash_we_n_o <= 1'b1;
						flash_oe_n_o <= 1'b1;
						cnt_r <= REC_LAST;
						state_r <= S_REC;
					end
				end
				S_REC:
				begin
					if (cnt_r != 4'h0)
						cnt_r <= cnt_r - 4'h1;
					else
					begin
						flash_dq_oe_o <= 1'b0;
						done_o <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

/* rtl/flash_erase_host.v */
// Functional notes
// - Host waits at least 200 us after resume before next suspend.
// - Bypass during suspend limits commands; host leaves bypass before resume.
// - On apparent failure host re-reads twice; both valid means complete.
// - Host presents a valid address on every status read.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"

module flash_erase_host #(
	parameter AW = 22,
	parameter RESUME_GAP_CYC = `RESUME_GAP_CYC
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire cmd_valid_i,
	input wire [1:0] cmd_i,
	input wire [AW-1:0] cmd_addr_i,
	input wire bypass_active_i,
	output reg cmd_ready_o,
	output reg done_o,
	output reg fail_o,
	output reg refused_o,
	output reg suspended_o,
	output reg busy_o,
	output reg [15:0] status_o,
	output wire [AW-1:0] flash_addr_o,
	output wire flash_ce_n_o,
	output wire flash_we_n_o,
	output wire flash_oe_n_o,
	output wire [15:0] flash_dq_o,
	output wire flash_dq_oe_o,
	input wire [15:0] flash_dq_i,
	input wire ready_busy_n_i
);

	localparam S_IDLE = 4'h0;
	localparam S_SEQ = 4'h1;
	localparam S_SEQ_WAIT = 4'h2;
	localparam S_POLL_A = 4'h3;
	localparam S_POLL_B = 4'h4;
	localparam S_VERIFY = 4'h5;
	localparam S_WAIT = 4'h6;
	localparam S_FINAL = 4'h7;
	localparam S_READ = 4'h8;

	localparam KIND_ERASE = 2'h0;
	localparam KIND_SUSPEND = 2'h1;
	localparam KIND_STATUS = 2'h2;

	localparam [15:0] SUSPEND_WAIT = `SUSPEND_WAIT_CYC;
	localparam [15:0] RESUME_GAP = RESUME_GAP_CYC;
	localparam [15:0] DATA_VALID = `DATA_VALID_CYC;
	localparam [15:0] ABORT_HOLD = `ABORT_HOLD_CYC;

	reg [3:0] state_r;
	reg [1:0] kind_r;
	reg [AW-1:0] addr_r;
	reg [2:0] idx_r;
	reg [2:0] len_r;
	reg [15:0] first_rd_r;
	reg [1:0] verify_r;
	reg [15:0] wait_r;
	reg [15:0] gap_r;
	reg bus_start_r;
	reg bus_write_r;
	reg [AW-1:0] bus_addr_r;
	reg [15:0] bus_data_r;
	reg rb_meta_r;
	reg rb_sync_r;
	wire bus_done;
	wire [15:0] bus_rdata;

	// ----------------------------------------
	// Command sequence table
	// ----------------------------------------
	// Returns {address low bits, code}; entry 0 of a one-word command is its code
	function [19:0] seq_word;
		input [2:0] idx;
		input [1:0] ucmd;
		begin
			case (ucmd)
				`UCMD_SUSPEND: seq_word = {12'h000, `CODE_SUSPEND};
				`UCMD_RESUME: seq_word = {12'h000, `CODE_RESUME};
				default:
				begin
					case (idx)
						3'h0: seq_word = {`ADDR_UNLOCK1, `CODE_UNLOCK1};
						3'h1: seq_word = {`ADDR_UNLOCK2, `CODE_UNLOCK2};
						3'h2: seq_word = {`ADDR_UNLOCK1, `CODE_ERASE_SETUP};
						3'h3: seq_word = {`ADDR_UNLOCK1, `CODE_UNLOCK1};
						3'h4: seq_word = {`ADDR_UNLOCK2, `CODE_UNLOCK2};
						default: seq_word = {`ADDR_CHIP_ERASE, `CODE_CHIP_ERASE};
					endcase
				end
			endcase
		end
	endfunction

	// Erase complete on poll bit alone; once done the bus carries array
	// data, so the abort bit is just a data bit here
	function status_ok;
		input [15:0] rd;
		begin
			status_ok = rd[`BIT_DATA_POLL];
		end
	endfunction

	reg [1:0] ucmd_r;
	wire [19:0] cur_word = seq_word(idx_r, ucmd_r);

	flash_bus_cycle #(
		.AW(AW)
	) u_bus (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.start_i(bus_start_r),
		.write_i(bus_write_r),
		.addr_i(bus_addr_r),
		.wdata_i(bus_data_r),
		.done_o(bus_done),
		.rdata_o(bus_rdata),
		.flash_addr_o(flash_addr_o),
		.flash_ce_n_o(flash_ce_n_o),
		.flash_we_n_o(flash_we_n_o),
		.flash_oe_n_o(flash_oe_n_o),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe_o(flash_dq_oe_o),
		.flash_dq_i(flash_dq_i)
	);

	// ----------------------------------------
	// Ready/busy synchroniser
	// ----------------------------------------
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rb_meta_r <= 1'b1;
			rb_sync_r <= 1'b1;
		end
		else
		begin
			rb_meta_r <= ready_busy_n_i;
			rb_sync_r <= rb_meta_r;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= S_IDLE;
			kind_r <= KIND_ERASE;
			ucmd_r <= `UCMD_CHIP_ERASE;
			addr_r <= {AW{1'b0}};
			idx_r <= 3'h0;
			len_r <= 3'h0;
			first_rd_r <= 16'h0000;
			verify_r <= 2'h0;
			wait_r <= 16'h0000;
			gap_r <= 16'h0000;
			bus_start_r <= 1'b0;
			bus_write_r <= 1'b0;
			bus_addr_r <= {AW{1'b0}};
			bus_data_r <= 16'h0000;
			cmd_ready_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			refused_o <= 1'b0;
			suspended_o <= 1'b0;
			busy_o <= 1'b0;
			status_o <= 16'h0000;
		end
		else
		begin
			bus_start_r <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			refused_o <= 1'b0;
			cmd_ready_o <= 1'b0;
			busy_o <= ~rb_sync_r;
			if (gap_r != 16'h0000)
				gap_r <= gap_r - 16'h0001;
			case (state_r)
				S_IDLE:
				begin
					cmd_ready_o <= 1'b1;
					if (cmd_valid_i && cmd_ready_o)
					begin
						cmd_ready_o <= 1'b0;
						ucmd_r <= cmd_i;
						addr_r <= cmd_addr_i;
						idx_r <= 3'h0;
						// A failed earlier command must not mark this one failed
						verify_r <= 2'h0;
						case (cmd_i)
							`UCMD_CHIP_ERASE:
							begin
								// Suspended erase must be resumed first
								if (suspended_o || bypass_active_i)
									refused_o <= 1'b1;
								else
								begin
									kind_r <= KIND_ERASE;
									len_r <= `CHIP_ERASE_LEN;
									state_r <= S_SEQ;
								end
							end
							`UCMD_SUSPEND:
							begin
								if (suspended_o || bypass_active_i || gap_r != 16'h0000)
									refused_o <= 1'b1;
								else
								begin
									kind_r <= KIND_SUSPEND;
									len_r <= 3'h1;
									state_r <= S_SEQ;
								end
							end
							`UCMD_RESUME:
							begin
								if (!suspended_o || bypass_active_i)
									refused_o <= 1'b1;
								else
								begin
									kind_r <= KIND_ERASE;
									len_r <= 3'h1;
									state_r <= S_SEQ;
								end
							end
							default:
							begin
								kind_r <= KIND_STATUS;
								state_r <= S_READ;
							end
						endcase
					end
				end
				S_SEQ:
				begin
					bus_start_r <= 1'b1;
					bus_write_r <= 1'b1;
					// One-word commands go to the caller's address; unlock cycles are low
					if (len_r == 3'h1)
						bus_addr_r <= addr_r;
					else
						bus_addr_r <= {{(AW-12){1'b0}}, cur_word[19:8]};
					bus_data_r <= {8'h00, cur_word[7:0]};
					state_r <= S_SEQ_WAIT;
				end
				S_SEQ_WAIT:
				begin
					if (bus_done)
					begin
						if (idx_r + 3'h1 < len_r)
						begin
							idx_r <= idx_r + 3'h1;
							state_r <= S_SEQ;
						end
						else if (kind_r == KIND_SUSPEND)
						begin
							wait_r <= SUSPEND_WAIT;
							state_r <= S_WAIT;
						end
						else
						begin
							if (ucmd_r == `UCMD_RESUME)
							begin
								suspended_o <= 1'b0;
								gap_r <= RESUME_GAP;
							end
							// Status sampled only after the final strobe has risen
							state_r <= S_POLL_A;
						end
					end
				end
				S_POLL_A, S_POLL_B, S_VERIFY, S_READ:
				begin
					bus_start_r <= 1'b1;
					bus_write_r <= 1'b0;
					bus_addr_r <= addr_r;
					state_r <= S_FINAL;
					wait_r <= {12'h000, state_r};
				end
				S_FINAL:
				begin
					if (bus_done)
					begin
						case (wait_r[3:0])
							S_POLL_A:
							begin
								first_rd_r <= bus_rdata;
								state_r <= S_POLL_B;
							end
							S_POLL_B:
							begin
								status_o <= bus_rdata;
								if (bus_rdata[`BIT_TOGGLE] != first_rd_r[`BIT_TOGGLE])
									state_r <= S_POLL_A;
								else if (status_ok(bus_rdata))
								begin
									wait_r <= DATA_VALID;
									verify_r <= 2'h0;
									state_r <= S_WAIT;
								end
								else
								begin
									verify_r <= `VERIFY_READS;
									state_r <= S_VERIFY;
								end
							end
							S_VERIFY:
							begin
								status_o <= bus_rdata;
								if (!status_ok(bus_rdata))
								begin
									// Let the abort status drop before next command
									wait_r <= ABORT_HOLD;
									verify_r <= 2'h3;
									state_r <= S_WAIT;
								end
								else if (verify_r == 2'h1)
								begin
									verify_r <= 2'h0;
									wait_r <= DATA_VALID;
									state_r <= S_WAIT;
								end
								else
								begin
									verify_r <= verify_r - 2'h1;
									state_r <= S_VERIFY;
								end
							end
							default:
							begin
								status_o <= bus_rdata;
								done_o <= 1'b1;
								state_r <= S_IDLE;
							end
						endcase
					end
				end
				S_WAIT:
				begin
					if (wait_r > 16'h0001)
						wait_r <= wait_r - 16'h0001;
					else
					begin
						if (kind_r == KIND_SUSPEND)
							suspended_o <= 1'b1;
						if (verify_r == 2'h3)
							fail_o <= 1'b1;
						else
							done_o <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

/* rtl/flash_host_defs.vh */
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CLK_MHZ 50
`define CLK_PERIOD_NS 20

// ----------------------------------------
// Command codes and addresses
// ----------------------------------------
`define CODE_UNLOCK1 8'hAA
`define CODE_UNLOCK2 8'h55
`define CODE_ERASE_SETUP 8'h80
`define CODE_CHIP_ERASE 8'h10
`define CODE_SUSPEND 8'hB0
`define CODE_RESUME 8'h30
`define ADDR_UNLOCK1 12'h555
`define ADDR_UNLOCK2 12'h2AA
`define ADDR_CHIP_ERASE 12'h555
`define CHIP_ERASE_LEN 3'h6

// ----------------------------------------
// User command encodings
// ----------------------------------------
`define UCMD_CHIP_ERASE 2'h0
`define UCMD_SUSPEND 2'h1
`define UCMD_RESUME 2'h2
`define UCMD_STATUS 2'h3

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define BIT_DATA_POLL 7
`define BIT_TOGGLE 6
`define BIT_SUSPEND_TOGGLE 2
`define BIT_BUFFER_ABORT 1

// ----------------------------------------
// Times and derived cycle counts
// ----------------------------------------
`define TIME_SUSPEND_MAX_US 20
`define SUSPEND_WAIT_CYC (`TIME_SUSPEND_MAX_US * `CLK_MHZ)
`define TIME_RESUME_GAP_US 200
`define RESUME_GAP_CYC (`TIME_RESUME_GAP_US * `CLK_MHZ)
`define TIME_ABORT_HOLD_NS 200
`define ABORT_HOLD_CYC ((`TIME_ABORT_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIME_DATA_VALID_US 1
`define DATA_VALID_CYC (`TIME_DATA_VALID_US * `CLK_MHZ)

// ----------------------------------------
// Bus cycle shaping, in clocks, and verify re-read count
// ----------------------------------------
`define WE_LOW_CYC 3
`define RD_LOW_CYC 6
`define RECOVER_CYC 2
`define VERIFY_READS 2'h2

`endif
